//--- crs_core_regs.sv
// Processor register set: status word, stack pointer, general registers, special window port
`timescale 1ns/10ps
module crs_core_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  irq_req,
  output logic             irq_ack,
  output logic      [2:0]  irq_vec,
  output logic             sfr_sel,
  output logic             sfr_we,
  output logic      [7:0]  sfr_addr,
  output logic      [1:0]  sfr_size,
  output logic      [2:0]  sfr_bit,
  output logic      [15:0] sfr_wdata,
  input  wire logic [15:0] sfr_rdata
);
  import crs_pkg::*;

  crs_bus_t    bst_q, bst_d;
  logic [7:0]  aoff_q;
  logic [31:0] rdat_q;
  logic [7:0]  psw_q, psw_d;
  logic [15:0] sp_q, sp_d;
  logic [7:0]  gpr_q [8];
  logic [7:0]  gpr_d [8];
  logic [7:0]  ram_q [2**RAM_AW];
  logic        ram_we;
  logic [6:0]  ram_wa;
  logic [7:0]  mask_q;
  logic [7:0]  rq1_q, rq2_q;
  logic [1:0]  flt_q, flt_d;
  logic [2:0]  lvec_q;
  logic        ack_q;
  logic [2:0]  vec_q;
  logic        ssel_q, swe_q;
  logic [7:0]  sadr_q;
  logic [1:0]  ssz_q;
  logic [2:0]  sbit_q;
  logic [15:0] swd_q, srd_q;
  logic [2:0]  sdst_q;
  logic [2:0]  irq_idx;
  logic        irq_any;
  logic [7:0]  pend_q;

  // Bus decode; reads take one wait state so that hrdata comes from a flop
  wire         addr_ok = hsel & htrans[1] & hready;
  wire         wr_dp   = (bst_q == ST_WR);
  wire         cmd_go  = wr_dp & (aoff_q == OFF_CMD);
  wire [3:0]   op      = hwdata[3:0];
  wire [2:0]   c_idx   = hwdata[6:4];
  wire [1:0]   c_pair  = hwdata[5:4];
  wire [1:0]   c_sub   = hwdata[9:8];
  wire [2:0]   c_bit   = hwdata[14:12];
  wire         c_swr   = hwdata[15];
  wire [7:0]   c_imm   = hwdata[23:16];
  wire [15:0]  c_imm16 = hwdata[31:16];
  wire [15:0]  c_sfra  = hwdata[31:16];
  wire [7:0]   opnd    = gpr_q[c_idx];
  wire [15:0]  sp_dec  = sp_q - 16'h0001;
  wire [15:0]  sp_inc  = sp_q + 16'h0001;
  wire         push_ok = (sp_dec[15:7] == RAM_PAGE);
  wire         pop_ok  = (sp_q[15:7] == RAM_PAGE);
  wire         sfr_win = (c_sfra[15:8] == SFR_PAGE);
  wire         sfr_par = (c_sub == SZ_WORD) & c_sfra[0];
  wire         sfr_ok  = sfr_win & ~sfr_par & (c_sub != 2'h3);
  wire [7:0]   pend    = rq2_q & ~mask_q;
  wire         irq_go  = psw_q[B_IE] & irq_any & ~cmd_go;
  wire         sfr_cap = ssel_q & ~swe_q;
  wire [8:0]   add_r   = {1'b0, opnd} + {1'b0, c_imm};
  wire [8:0]   sub_r   = {1'b0, opnd} - {1'b0, c_imm};
  wire [4:0]   add_n   = {1'b0, opnd[3:0]} + {1'b0, c_imm[3:0]};
  wire         alu_sub = c_sub[0];
  wire [7:0]   alu_r   = alu_sub ? sub_r[7:0] : add_r[7:0];
  wire         alu_cy  = alu_sub ? sub_r[8] : add_r[8];
  wire         alu_ac  = alu_sub ? (opnd[3:0] < c_imm[3:0]) : add_n[4];
  wire         rbit    = opnd[c_bit];

  // Lowest numbered unmasked pending source wins
  always_comb begin
    irq_idx = 3'h0;
    irq_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i]) begin
        irq_idx = 3'(i);
        irq_any = 1'b1;
      end
    end
  end

  always_comb begin
    bst_d = ST_IDLE;
    case (bst_q)
      ST_RD1:  bst_d = ST_RD2;
      default: begin
        if (addr_ok) begin
          bst_d = hwrite ? ST_WR : ST_RD1;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bst_q  <= ST_IDLE;
      aoff_q <= 8'h00;
    end else begin
      bst_q <= bst_d;
      if (addr_ok) begin
        aoff_q <= haddr[7:0];
      end
    end
  end

  // Read mux sampled in the wait cycle, after any preceding write has landed
  wire [31:0] rd_mux =
    (aoff_q == OFF_PSW)  ? {24'h000000, psw_q} :
    (aoff_q == OFF_SP)   ? {16'h0000, sp_q} :
    (aoff_q == OFF_GLO)  ? {gpr_q[3], gpr_q[2], gpr_q[1], gpr_q[0]} :
    (aoff_q == OFF_GHI)  ? {gpr_q[7], gpr_q[6], gpr_q[5], gpr_q[4]} :
    (aoff_q == OFF_STAT) ? {27'h0000000, lvec_q, flt_q} :
    (aoff_q == OFF_MASK) ? {24'h000000, mask_q} :
    (aoff_q == OFF_PEND) ? {24'h000000, rq2_q} :
    (aoff_q == OFF_SFRD) ? {16'h0000, srd_q} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdat_q <= 32'h00000000;
    end else if (bst_q == ST_RD1) begin
      rdat_q <= rd_mux;
    end
  end

  assign hrdata    = rdat_q;
  assign hreadyout = (bst_q != ST_RD1);
  assign hresp     = 1'b0;

  // Requests come from other logic at unknown phase, so they are synchronised first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rq1_q <= 8'h00;
      rq2_q <= 8'h00;
    end else begin
      rq1_q <= irq_req;
      rq2_q <= rq1_q;
    end
  end

  // Main datapath: one command or one interrupt acknowledge per cycle
  always_comb begin
    psw_d  = psw_q;
    sp_d   = sp_q;
    flt_d  = flt_q;
    ram_we = 1'b0;
    ram_wa = sp_dec[6:0];
    for (int i = 0; i < 8; i++) begin
      gpr_d[i] = gpr_q[i];
    end
    if (sfr_cap) begin
      if (ssz_q == SZ_BIT) begin
        psw_d[B_CY] = sfr_rdata[sbit_q];
      end else if (ssz_q == SZ_WORD) begin
        gpr_d[{sdst_q[1:0], 1'b0}] = sfr_rdata[7:0];
        gpr_d[{sdst_q[1:0], 1'b1}] = sfr_rdata[15:8];
      end else begin
        gpr_d[sdst_q] = sfr_rdata[7:0];
      end
    end
    if (wr_dp) begin
      case (aoff_q)
        OFF_PSW:  psw_d = (hwdata[7:0] & PSW_WMASK) | PSW_RST;
        OFF_SP:   sp_d  = hwdata[15:0];
        OFF_GLO:  begin
          for (int i = 0; i < 4; i++) begin
            gpr_d[i] = hwdata[8*i +: 8];
          end
        end
        OFF_GHI:  begin
          for (int i = 0; i < 4; i++) begin
            gpr_d[i+4] = hwdata[8*i +: 8];
          end
        end
        OFF_STAT: flt_d = flt_q & ~hwdata[1:0];
        default:  ;
      endcase
    end
    if (cmd_go) begin
      case (op)
        OP_EI:      psw_d[B_IE] = 1'b1;
        OP_DI:      psw_d[B_IE] = 1'b0;
        OP_PUSHPSW: begin
          if (push_ok) begin
            sp_d   = sp_dec;
            ram_we = 1'b1;
          end else begin
            flt_d[STAT_STK] = 1'b1;
          end
        end
        OP_POPPSW, OP_RETURN_FROM_IRQ: begin
          if (pop_ok) begin
            psw_d = (ram_q[sp_q[6:0]] & PSW_WMASK) | PSW_RST;
            sp_d  = sp_inc;
          end else begin
            flt_d[STAT_STK] = 1'b1;
          end
        end
        OP_ALU: begin
          gpr_d[c_idx] = alu_r;
          psw_d[B_Z]   = (alu_r == 8'h00);
          psw_d[B_AC]  = alu_ac;
          psw_d[B_CY]  = alu_cy;
        end
        OP_ROT: begin
          if (c_sub[0]) begin
            gpr_d[c_idx] = {opnd[0], opnd[7:1]};
            psw_d[B_CY]  = opnd[0];
          end else begin
            gpr_d[c_idx] = {opnd[6:0], opnd[7]};
            psw_d[B_CY]  = opnd[7];
          end
        end
        OP_BIT: begin
          case (c_sub)
            2'h0:    psw_d[B_CY] = rbit;
            2'h1:    psw_d[B_CY] = psw_q[B_CY] & rbit;
            2'h2:    psw_d[B_CY] = psw_q[B_CY] | rbit;
            default: psw_d[B_CY] = psw_q[B_CY] ^ rbit;
          endcase
        end
        OP_REGWR:  gpr_d[c_idx] = c_imm;
        OP_PAIRWR: begin
          gpr_d[{c_pair, 1'b0}] = c_imm16[7:0];
          gpr_d[{c_pair, 1'b1}] = c_imm16[15:8];
        end
        OP_SFR: begin
          if (!sfr_ok) begin
            flt_d[STAT_SFR] = 1'b1;
          end
        end
        default: ;
      endcase
    end else if (irq_go) begin
      psw_d[B_IE] = 1'b0;
      if (push_ok) begin
        sp_d   = sp_dec;
        ram_we = 1'b1;
      end else begin
        flt_d[STAT_STK] = 1'b1;
      end
    end
  end

  // Reset does not define the stack pointer; it is cleared so that simulation is deterministic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psw_q  <= PSW_RST;
      sp_q   <= SP_RST;
      flt_q  <= 2'h0;
      mask_q <= MASK_RST;
      for (int i = 0; i < 8; i++) begin
        gpr_q[i] <= 8'h00;
      end
    end else begin
      psw_q <= psw_d;
      sp_q  <= sp_d;
      flt_q <= flt_d;
      for (int i = 0; i < 8; i++) begin
        gpr_q[i] <= gpr_d[i];
      end
      if (wr_dp && aoff_q == OFF_MASK) begin
        mask_q <= hwdata[7:0];
      end
    end
  end

  // Stack RAM; the pre-decremented address is written, the saved byte is the old status word
  always_ff @(posedge hclk) begin
    if (ram_we) begin
      ram_q[ram_wa] <= psw_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_q  <= 1'b0;
      vec_q  <= 3'h0;
      lvec_q <= 3'h0;
      pend_q <= 8'h00;
    end else begin
      ack_q  <= irq_go;
      pend_q <= pend;
      if (irq_go) begin
        vec_q  <= irq_idx;
        lvec_q <= irq_idx;
      end
    end
  end

  assign irq_ack = ack_q;
  assign irq_vec = vec_q;

  // Special window port: one strobe cycle, read data captured at its end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ssel_q <= 1'b0;
      swe_q  <= 1'b0;
      sadr_q <= 8'h00;
      ssz_q  <= SZ_BYTE;
      sbit_q <= 3'h0;
      swd_q  <= 16'h0000;
      sdst_q <= 3'h0;
      srd_q  <= 16'h0000;
    end else begin
      ssel_q <= cmd_go & (op == OP_SFR) & sfr_ok;
      if (cmd_go && op == OP_SFR) begin
        swe_q  <= c_swr;
        sadr_q <= c_sfra[7:0];
        ssz_q  <= c_sub;
        sbit_q <= c_bit;
        sdst_q <= c_idx;
        if (c_sub == SZ_WORD) begin
          swd_q <= {gpr_q[{c_pair, 1'b1}], gpr_q[{c_pair, 1'b0}]};
        end else if (c_sub == SZ_BIT) begin
          swd_q <= {15'h0000, psw_q[B_CY]};
        end else begin
          swd_q <= {8'h00, opnd};
        end
      end
      if (sfr_cap) begin
        srd_q <= (ssz_q == SZ_BIT) ? {15'h0000, sfr_rdata[sbit_q]} : sfr_rdata;
      end
    end
  end

  assign sfr_sel   = ssel_q;
  assign sfr_we    = swe_q;
  assign sfr_addr  = sadr_q;
  assign sfr_size  = ssz_q;
  assign sfr_bit   = sbit_q;
  assign sfr_wdata = swd_q;

  // Pending set as seen in the cycle the acknowledge was taken
  wire ack_ok = irq_ack & pend_q[irq_vec];

  sequence s_rd_accept;
    addr_ok && !hwrite;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_PSW_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> psw_q == PSW_RST) else $error("status word not 02H after reset");
  AST_DI_REFUSE: assert property (@(posedge hclk) disable iff (!hresetn)
    !psw_q[B_IE] |=> !irq_ack) else $error("interrupt taken while disabled");
  AST_MASK_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_ack |-> ack_ok) else $error("masked or idle source acknowledged");
  AST_ACK_CLR_IE: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_ack |-> !psw_q[B_IE] && $past(psw_q[B_IE])) else $error("acknowledge left enable set");
  AST_PUSH_DEC: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_go && push_ok) |=> sp_q == $past(sp_dec)) else $error("push did not pre-decrement");
  AST_POP_INC: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_go && op == OP_POPPSW && pop_ok) |=> sp_q == $past(sp_inc) &&
      psw_q == (($past(ram_q[sp_q[6:0]]) & PSW_WMASK) | PSW_RST))
    else $error("pop did not restore status word");
  AST_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_go && op == OP_ALU) |=> psw_q[B_Z] == ($past(alu_r) == 8'h00))
    else $error("zero flag wrong after operation");
  AST_SFR_WIN: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_go && op == OP_SFR && !sfr_win) |=> !sfr_sel && flt_q[STAT_SFR])
    else $error("access outside window issued");
  AST_SFR_EVEN: assert property (@(posedge hclk) disable iff (!hresetn)
    (sfr_sel && sfr_size == SZ_WORD) |-> !sfr_addr[0]) else $error("odd word access issued");
  AST_RD_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rd_accept |=> s_rd_answer) else $error("read answer not after one wait");
endmodule : crs_core_regs

//--- crs_pkg.sv
// Constants and encodings for the processor register set block
// Operation
// - Reset loads the status word with 02H.
// - Interrupt acknowledge and push-status save status word; return and pop reload it.
// - With global enable clear, every interrupt request is refused.
// - With global enable set, each source's own mask decides acceptance.
// - Disable instruction and acknowledge clear global enable; enable instruction sets it.
// - Zero flag is one for a zero result, else zero.
// - Half carry is set on carry out of or borrow into bit 3.
// - Carry flag captures add overflow and subtract underflow.
// - Rotate puts shifted-out bit in carry; bit operations use carry as accumulator.
// - Stack pointer is 16 bits; only internal fast RAM may hold the stack.
// - Stack pointer decrements before a save and increments after a restore.
// - Eight 8-bit general registers X, A, C, B, E, D, L, H.
// - Pairs AX, BC, DE, HL; A, B, D, H are upper bytes.
// - Registers selectable by absolute index 0-7 and pairs 0-3.
// - Special function registers decode only in FF00H to FFFFH.
// - Special function registers take 1-, 8- and 16-bit accesses.
// - Single-bit access selects register address plus bit index.
package crs_pkg;
  localparam logic [7:0]  OFF_PSW    = 8'h00;
  localparam logic [7:0]  OFF_SP     = 8'h04;
  localparam logic [7:0]  OFF_GLO    = 8'h08;
  localparam logic [7:0]  OFF_GHI    = 8'h0C;
  localparam logic [7:0]  OFF_CMD    = 8'h10;
  localparam logic [7:0]  OFF_STAT   = 8'h14;
  localparam logic [7:0]  OFF_MASK   = 8'h18;
  localparam logic [7:0]  OFF_PEND   = 8'h1C;
  localparam logic [7:0]  OFF_SFRD   = 8'h20;
  localparam logic [7:0]  PSW_RST    = 8'h02;
  localparam logic [7:0]  PSW_WMASK  = 8'hD1;
  localparam int          B_IE       = 7;
  localparam int          B_Z        = 6;
  localparam int          B_AC       = 4;
  localparam int          B_CY       = 0;
  localparam logic [15:0] SP_RST     = 16'h0000;
  localparam logic [8:0]  RAM_PAGE   = 9'h1FD;
  localparam int          RAM_AW     = 7;
  localparam logic [7:0]  SFR_PAGE   = 8'hFF;
  localparam logic [7:0]  MASK_RST   = 8'hFF;
  localparam logic [3:0]  OP_NOP     = 4'h0;
  localparam logic [3:0]  OP_EI      = 4'h1;
  localparam logic [3:0]  OP_DI      = 4'h2;
  localparam logic [3:0]  OP_PUSHPSW = 4'h3;
  localparam logic [3:0]  OP_POPPSW  = 4'h4;
  localparam logic [3:0]  OP_RETURN_FROM_IRQ    = 4'h5;
  localparam logic [3:0]  OP_ALU     = 4'h6;
  localparam logic [3:0]  OP_ROT     = 4'h7;
  localparam logic [3:0]  OP_BIT     = 4'h8;
  localparam logic [3:0]  OP_REGWR   = 4'h9;
  localparam logic [3:0]  OP_PAIRWR  = 4'hA;
  localparam logic [3:0]  OP_SFR     = 4'hB;
  localparam logic [1:0]  SZ_BIT     = 2'h0;
  localparam logic [1:0]  SZ_BYTE    = 2'h1;
  localparam logic [1:0]  SZ_WORD    = 2'h2;
  localparam int          STAT_STK   = 0;
  localparam int          STAT_SFR   = 1;
  typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD1, ST_RD2} crs_bus_t;
endpackage : crs_pkg

//--- test_cpu_core_register_set.sv
// Self-checking testbench for the processor register set
`timescale 1ns/10ps
module test_cpu_core_register_set;
  import crs_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  irq_req = 8'h00;
  logic        irq_ack;
  logic [2:0]  irq_vec;
  logic        sfr_sel;
  logic        sfr_we;
  logic [7:0]  sfr_addr;
  logic [1:0]  sfr_size;
  logic [2:0]  sfr_bit;
  logic [15:0] sfr_wdata;
  logic [15:0] sfr_rdata = 16'h0;
  logic [31:0] seed = 32'h0001_7642;
  logic [2:0]  ack_vec;
  logic [29:0] sfr_cap;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_ack = 0;
  int          n_sfr = 0;

  crs_core_regs crs_core_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
    .irq_ack(irq_ack), .irq_vec(irq_vec), .sfr_sel(sfr_sel), .sfr_we(sfr_we),
    .sfr_addr(sfr_addr), .sfr_size(sfr_size), .sfr_bit(sfr_bit), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));

  always #10 hclk = ~hclk;

  // Pulses are sampled mid-cycle so flop updates at the edge never race the monitor
  always @(negedge hclk) begin
    if (irq_ack === 1'b1) begin
      n_ack++;
      ack_vec = irq_vec;
    end
    if (sfr_sel === 1'b1) begin
      n_sfr++;
      sfr_cap = {sfr_we, sfr_addr, sfr_size, sfr_bit, sfr_wdata};
    end
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Returns zero, half carry, carry and the 8-bit result
  function automatic logic [10:0] alu_exp(input logic [7:0] r, input logic [7:0] k,
                                          input logic s);
    logic [8:0] w;
    logic       h;
    w = s ? {1'b0, r} - {1'b0, k} : {1'b0, r} + {1'b0, k};
    h = s ? (r[3:0] < k[3:0]) : (({1'b0, r[3:0]} + {1'b0, k[3:0]}) > 5'h0F);
    return {w[7:0] == 8'h00, h, w[8], w[7:0]};
  endfunction : alu_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address phase held until hready, then data phase held until hready again
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    @(posedge hclk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] u;
    bus(1'b1, a, d, u);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask : rd

  task automatic cmd(input logic [3:0] op, input logic [2:0] idx, input logic [1:0] sub,
                     input logic [2:0] bt, input logic sw, input logic [15:0] imm);
    wr(OFF_CMD, {imm, sw, bt, 2'h0, sub, 1'b0, idx, op});
    // A special-window read shares the register write path, so leave a gap
    repeat (2) @(posedge hclk);
  endtask : cmd

  task automatic regs(output logic [63:0] f);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(OFF_GLO, lo);
    rd(OFF_GHI, hi);
    f = {hi, lo};
  endtask : regs

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    logic [31:0] d;
    logic [31:0] s0;
    logic [63:0] f;
    logic [63:0] fe;
    logic [7:0]  v;
    logic [7:0]  k;
    logic [2:0]  i;
    logic [2:0]  b;
    logic [1:0]  s;
    logic        c;
    logic [10:0] e;
    logic [16:0] corner [4];
    logic [17:0] bad [3];
    int          n0;
    corner = '{17'h0_0F01, 17'h0_FF01, 17'h1_0001, 17'h1_1001};
    bad = '{{16'h1234, 2'h1}, {16'hFF13, 2'h2}, {16'hFF02, 2'h3}};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_PSW, d);
    chk(d, {24'h0, PSW_RST});
    chk({31'h0, hresp}, 32'h0);
    rd(OFF_MASK, d);
    chk(d, 32'h0000_00FF);
    rd(8'h40, d);
    chk(d, 32'h0);
    wr(OFF_PSW, 32'h0000_00FF);
    rd(OFF_PSW, d);
    chk(d, 32'h0000_00D3);
    wr(OFF_PSW, 32'h0);
    cmd(OP_EI, 3'h0, 2'h0, 3'h0, 1'b0, 16'h0);
    rd(OFF_PSW, d);
    chk(d, 32'h0000_0082);
    cmd(OP_DI, 3'h0, 2'h0, 3'h0, 1'b0, 16'h0);
    rd(OFF_PSW, d);
    chk(d, 32'h0000_0002);
    done("reset");
    fe = {rnd(), rnd()};
    wr(OFF_GLO, fe[31:0]);
    wr(OFF_GHI, fe[63:32]);
    for (int n = 0; n < 8; n++) begin
      v = rnd();
      cmd(OP_REGWR, n[2:0], 2'h0, 3'h0, 1'b0, {8'h0, v});
      fe[8*n +: 8] = v;
    end
    d = rnd();
    cmd(OP_PAIRWR, {1'b0, d[17:16]}, 2'h0, 3'h0, 1'b0, d[15:0]);
    fe[16*d[17:16] +: 16] = d[15:0];
    regs(f);
    chk(f[31:0], fe[31:0]);
    chk(f[63:32], fe[63:32]);
    done("registers");
    for (int n = 0; n < 20; n++) begin
      d = rnd();
      i = d[2:0];
      {s[0], v, k} = (n < 4) ? corner[n] : {d[3], d[15:8], d[23:16]};
      e = alu_exp(v, k, s[0]);
      cmd(OP_REGWR, i, 2'h0, 3'h0, 1'b0, {8'h0, v});
      cmd(OP_ALU, i, {1'b0, s[0]}, 3'h0, 1'b0, {8'h0, k});
      regs(f);
      chk({24'h0, f[8*i +: 8]}, {24'h0, e[7:0]});
      rd(OFF_PSW, d);
      chk(d, {24'h0, 1'b0, e[10], 1'b0, e[9], 3'h1, e[8]});
    end
    done("alu");
    for (int n = 0; n < 8; n++) begin
      d = rnd();
      {i, v, b, s} = {d[2:0], d[15:8], d[18:16], n[1:0]};
      cmd(OP_REGWR, i, 2'h0, 3'h0, 1'b0, {8'h0, v});
      cmd(OP_ROT, i, {1'b0, n[0]}, 3'h0, 1'b0, 16'h0);
      k = n[0] ? {v[0], v[7:1]} : {v[6:0], v[7]};
      regs(f);
      chk({24'h0, f[8*i +: 8]}, {24'h0, k});
      rd(OFF_PSW, d);
      chk({31'h0, d[0]}, {31'h0, n[0] ? v[0] : v[7]});
      cmd(OP_BIT, i, 2'h0, ~b, 1'b0, 16'h0);
      cmd(OP_BIT, i, s, b, 1'b0, 16'h0);
      // Bit operations see the rotated register, not the value first loaded
      c = k[~b];
      c = (s == 2'h0) ? k[b] : (s == 2'h1) ? c & k[b] : (s == 2'h2) ? c | k[b] : c ^ k[b];
      rd(OFF_PSW, d);
      chk({31'h0, d[0]}, {31'h0, c});
    end
    done("rotate and bit");
    wr(OFF_SP, 32'h0000_FF00);
    rd(OFF_PSW, s0);
    cmd(OP_PUSHPSW, 3'h0, 2'h0, 3'h0, 1'b0, 16'h0);
    rd(OFF_SP, d);
    chk(d & 32'hFFFF, 32'h0000_FEFF);
    wr(OFF_PSW, 32'h0000_00D1);
    cmd(OP_POPPSW, 3'h0, 2'h0, 3'h0, 1'b0, 16'h0);
    rd(OFF_PSW, d);
    chk(d, s0);
    rd(OFF_SP, d);
    chk(d & 32'hFFFF, 32'h0000_FF00);
    wr(OFF_SP, 32'h0000_FE80);
    cmd(OP_PUSHPSW, 3'h0, 2'h0, 3'h0, 1'b0, 16'h0);
    rd(OFF_SP, d);
    chk(d & 32'hFFFF, 32'h0000_FE80);
    rd(OFF_STAT, d);
    chk({31'h0, d[STAT_STK]}, 32'h1);
    done("stack");
    wr(OFF_SP, 32'h0000_FF00);
    n0 = n_ack;
    wr(OFF_MASK, 32'h0000_00F3);
    irq_req <= 8'h0C;
    repeat (8) @(posedge hclk);
    chk(32'(n_ack - n0), 32'h0);
    rd(OFF_PEND, d);
    chk(d, 32'h0000_000C);
    wr(OFF_MASK, 32'h0000_00FF);
    cmd(OP_EI, 3'h0, 2'h0, 3'h0, 1'b0, 16'h0);
    repeat (8) @(posedge hclk);
    chk(32'(n_ack - n0), 32'h0);
    rd(OFF_PSW, s0);
    wr(OFF_MASK, 32'h0000_00F3);
    for (int t = 0; t < 10 && n_ack == n0; t++) @(posedge hclk);
    chk(32'(n_ack - n0), 32'h1);
    chk({29'h0, ack_vec}, 32'h2);
    rd(OFF_STAT, d);
    chk({29'h0, d[4:2]}, 32'h2);
    irq_req <= 8'h00;
    rd(OFF_PSW, d);
    chk(d, s0 & 32'h7F);
    rd(OFF_SP, d);
    chk(d & 32'hFFFF, 32'h0000_FEFF);
    cmd(OP_RETURN_FROM_IRQ, 3'h0, 2'h0, 3'h0, 1'b0, 16'h0);
    rd(OFF_PSW, d);
    chk(d, s0);
    chk(32'(n_ack - n0), 32'h1);
    wr(OFF_MASK, 32'h0000_00FF);
    done("interrupt");
    d = rnd();
    sfr_rdata <= d[15:0];
    n0 = n_sfr;
    regs(f);
    cmd(OP_SFR, 3'h1, SZ_BYTE, 3'h0, 1'b1, 16'hFFFF);
    chk({18'h0, sfr_cap[29:16]}, {18'h0, 1'b1, 8'hFF, SZ_BYTE, 3'h0});
    chk({24'h0, sfr_cap[7:0]}, {24'h0, f[15:8]});
    cmd(OP_SFR, 3'h2, SZ_WORD, 3'h0, 1'b1, 16'hFF00);
    chk({16'h0, sfr_cap[15:0]}, {16'h0, f[47:32]});
    cmd(OP_SFR, 3'h5, SZ_BYTE, 3'h0, 1'b0, 16'hFF31);
    cmd(OP_SFR, 3'h3, SZ_WORD, 3'h0, 1'b0, 16'hFF12);
    regs(f);
    chk({24'h0, f[47:40]}, {24'h0, d[7:0]});
    chk({16'h0, f[63:48]}, {16'h0, d[15:0]});
    rd(OFF_SFRD, s0);
    chk(s0, {16'h0, d[15:0]});
    cmd(OP_SFR, 3'h0, SZ_BIT, 3'h5, 1'b0, 16'hFF02);
    chk({18'h0, sfr_cap[29:16]}, {18'h0, 1'b0, 8'h02, SZ_BIT, 3'h5});
    rd(OFF_PSW, s0);
    chk({31'h0, s0[0]}, {31'h0, d[5]});
    chk(32'(n_sfr - n0), 32'h5);
    for (int n = 0; n < 3; n++) begin
      wr(OFF_STAT, 32'h2);
      cmd(OP_SFR, 3'h0, bad[n][1:0], 3'h0, 1'b0, bad[n][17:2]);
      rd(OFF_STAT, s0);
      chk({31'h0, s0[STAT_SFR]}, 32'h1);
    end
    chk(32'(n_sfr - n0), 32'h5);
    done("special window");
    report_and_stop();
  end
endmodule : test_cpu_core_register_set
